//--- src/combiner_map.svh
`ifndef COMBINER_MAP_SVH
`define COMBINER_MAP_SVH

// Register word offsets on the Avalon-MM slave
`define REG_TERM_SEL0    5'h00
`define REG_RELAY_SEL    5'h05
`define REG_RESULT_CFG0  5'h06
`define REG_TO_LIMIT     5'h0C
`define REG_FAN_CTRL     5'h0D
`define REG_LINK_CFG     5'h0E
`define REG_MONITOR      5'h0F
`define REG_EVT_STATUS   5'h10
`define REG_EVT_MASK     5'h11

// Field positions of a result configuration word
`define CFG_SRC1_LSB     0
`define CFG_SRC2_LSB     8
`define CFG_OP_LSB       16

// Field positions of the monitor word
`define MON_CAP_BIT      0
`define MON_FAN_BIT      1
`define MON_LINK_BIT     2
`define MON_RESULT_LSB   8

// Output-signal codes with a fixed meaning
`define CODE_LINK        6'h20
`define CODE_RESULT_LO   6'h21
`define CODE_RESULT_HI   6'h26
`define CODE_CAP         6'h27
`define CODE_FAN         6'h28
`define CODE_MAX         6'h38

// Operator codes and setting values
`define OP_AND           2'h0
`define OP_OR            2'h1
`define OP_XOR           2'h2
`define FAN_CTRL_NO_WARN 2'h1
`define LINK_MODBUS_485  2'h3

// Reset values and the highest timeout limit
`define RST_SEL          6'h00
`define RST_OP           2'h0
`define RST_TO_LIMIT     14'h0000
`define RST_MASK         3'h0
`define TO_LIMIT_MAX     14'h270F

// Timing and thresholds
`define CLK_HZ           125000000
`define TICK_MS          10
`define FAN_DROP_PCT     75

`endif

//--- src/combiner_pkg.sv
`include "combiner_map.svh"

package combiner_pkg;

  // Avalon handshake states
  typedef enum logic [1:0] {
    BUS_IDLE = 2'b01,
    BUS_ACK  = 2'b10
  } bus_state_t;

  // Whole state of the combiner
  typedef struct packed {
    bus_state_t       bus;
    logic             waitreq;
    logic [31:0]      rdata;
    logic [4:0][5:0]  term_sel;
    logic [5:0]       relay_sel;
    logic [5:0][5:0]  src1;
    logic [5:0][5:0]  src2;
    logic [5:0][1:0]  op;
    logic [13:0]      to_limit;
    logic [1:0]       fan_ctrl;
    logic [1:0]       link_cfg;
    logic [31:0]      tick_cnt;
    logic [13:0]      to_cnt;
    logic             link_flag;
    logic [31:0]      life_cnt;
    logic             cap_warn;
    logic             fan_drop;
    logic [2:0]       evt_status;
    logic [2:0]       evt_mask;
    logic             irq;
    logic [4:0]       term_out;
    logic             relay_out;
  } state_t;

  // Picks one output signal by code; result codes and codes past the top read as 0
  function automatic logic pick(input logic [63:0] vec, input logic [5:0] code);
    if ((code >= `CODE_RESULT_LO && code <= `CODE_RESULT_HI) || code > `CODE_MAX)
      return 1'b0;
    return vec[code];
  endfunction

endpackage

//--- src/logic_result_unit.sv
`timescale 1ns/1ps
`default_nettype none
`include "combiner_map.svh"

module logic_result_unit (
  // Source signals and selection
  input  wire logic [63:0] src_vec_i,
  input  wire logic [5:0]  sel1_i,
  input  wire logic [5:0]  sel2_i,
  input  wire logic [1:0]  op_i,
  // Combined result
  output logic             result_o
);

  logic a;
  logic b;

  // Two independent selectors that cannot pick another result
  always_comb begin
    a = combiner_pkg::pick(src_vec_i, sel1_i);
    b = combiner_pkg::pick(src_vec_i, sel2_i);
    unique case (op_i)
      `OP_AND: result_o = a & b;
      `OP_OR:  result_o = a | b;
      `OP_XOR: result_o = a ^ b;
      default: result_o = 1'b0;
    endcase
  end

endmodule

`default_nettype wire

//--- src/output_signal_logic_combiner.sv
// Our own choices: the register offsets and the Avalon-MM interface to the registers.
`timescale 1ns/1ps
`default_nettype none
`include "combiner_map.svh"

module output_signal_logic_combiner #(
  parameter int unsigned TICK_CYCLES     = `CLK_HZ / 1000 * `TICK_MS,
  parameter logic [31:0] LIFE_LIMIT      = 32'h0FFF_FFFF,
  parameter logic [7:0]  HOT_TEMP        = 8'h50,
  parameter logic [7:0]  FAN_FULL_SPEED  = 8'hFF
) (
  // Clock and reset
  input  wire logic        clock_i,
  input  wire logic        rst_i,
  // Avalon-MM slave
  input  wire logic [4:0]  address_i,
  input  wire logic        read_i,
  input  wire logic        write_i,
  input  wire logic [31:0] writedata_i,
  input  wire logic [3:0]  byteenable_i,
  output logic [31:0]      readdata_o,
  output logic             waitrequest_o,
  output logic             irq_o,
  // Drive status inputs
  input  wire logic [56:0] out_sig_i,
  input  wire logic        rx_data_i,
  input  wire logic [7:0]  temp_i,
  input  wire logic [7:0]  fan_speed_i,
  // Terminals 11 to 15 and alarm relay
  output logic [4:0]       term_o,
  output logic             relay_o
);

  combiner_pkg::state_t s;
  combiner_pkg::state_t n;
  logic [63:0] src_vec;
  logic [5:0]  results;
  logic        tick;
  logic        link_en;
  logic        expire;
  logic        fan_slow;
  logic [31:0] cur_word;
  logic [31:0] wr_word;
  logic [2:0]  evt;
  logic [2:0]  clr;
  logic [4:0]  cfg_idx;

  // Routes a function code to a result, an internal flag or a plain signal
  function automatic logic route(input logic [5:0] code, input logic [63:0] vec,
                                 input logic [5:0] res);
    logic [5:0] idx;
    idx = 6'(code - `CODE_RESULT_LO);
    if (code >= `CODE_RESULT_LO && code <= `CODE_RESULT_HI)
      return res[idx[2:0]];
    return combiner_pkg::pick(vec, code);
  endfunction

  // Applies Avalon byte enables to a register word
  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] wd,
                                        input logic [3:0] be);
    logic [31:0] m;
    m = {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}};
    return (old & ~m) | (wd & m);
  endfunction

  // Source vector: external signals with internal flags at their codes
  always_comb begin
    src_vec = {7'h00, out_sig_i};
    src_vec[`CODE_LINK] = s.link_flag;
    src_vec[`CODE_CAP] = s.cap_warn;
    src_vec[`CODE_FAN] = s.fan_drop;
  end

  // Six independent result units
  for (genvar g = 0; g < 6; g++) begin : g_result
    logic_result_unit u_unit (
      .src_vec_i (src_vec),
      .sel1_i    (s.src1[g]),
      .sel2_i    (s.src2[g]),
      .op_i      (s.op[g]),
      .result_o  (results[g])
    );
  end

  // Flag conditions
  assign tick = s.tick_cnt == 32'(TICK_CYCLES - 1);
  assign link_en = s.link_cfg == `LINK_MODBUS_485;
  assign expire = link_en && tick && !s.link_flag && s.to_limit != 14'h0000 &&
                  (s.to_cnt + 14'h0001) >= s.to_limit;
  assign fan_slow = ({7'h00, fan_speed_i} * 15'h0064) <=
                    ({7'h00, FAN_FULL_SPEED} * 15'(`FAN_DROP_PCT));
  assign cfg_idx = 5'(address_i - `REG_RESULT_CFG0);

  // Register readback of the current state
  always_comb begin
    cur_word = 32'h0000_0000;
    if (address_i <= 5'h04) begin
      cur_word[5:0] = s.term_sel[address_i[2:0]];
    end else if (address_i == `REG_RELAY_SEL) begin
      cur_word[5:0] = s.relay_sel;
    end else if (address_i >= `REG_RESULT_CFG0 && address_i < `REG_TO_LIMIT) begin
      cur_word[`CFG_SRC1_LSB +: 6] = s.src1[cfg_idx[2:0]];
      cur_word[`CFG_SRC2_LSB +: 6] = s.src2[cfg_idx[2:0]];
      cur_word[`CFG_OP_LSB +: 2] = s.op[cfg_idx[2:0]];
    end else begin
      unique case (address_i)
        `REG_TO_LIMIT:   cur_word[13:0] = s.to_limit;
        `REG_FAN_CTRL:   cur_word[1:0] = s.fan_ctrl;
        `REG_LINK_CFG:   cur_word[1:0] = s.link_cfg;
        `REG_MONITOR: begin
          cur_word[`MON_CAP_BIT] = s.cap_warn;
          cur_word[`MON_FAN_BIT] = s.fan_drop;
          cur_word[`MON_LINK_BIT] = s.link_flag;
          cur_word[`MON_RESULT_LSB +: 6] = results;
        end
        `REG_EVT_STATUS: cur_word[2:0] = s.evt_status;
        `REG_EVT_MASK:   cur_word[2:0] = s.evt_mask;
        default:         cur_word = 32'h0000_0000;
      endcase
    end
    wr_word = merge(cur_word, writedata_i, byteenable_i);
  end

  // Next state of the whole block
  always_comb begin
    n = s;
    clr = 3'h0;
    n.tick_cnt = tick ? 32'h0000_0000 : s.tick_cnt + 32'h0000_0001;
    // Avalon handshake: answer one cycle after the request, act when released
    unique case (s.bus)
      combiner_pkg::BUS_IDLE: begin
        if (read_i || write_i) begin
          n.bus = combiner_pkg::BUS_ACK;
          n.waitreq = 1'b0;
          n.rdata = read_i ? cur_word : 32'h0000_0000;
        end
      end
      combiner_pkg::BUS_ACK: begin
        n.bus = combiner_pkg::BUS_IDLE;
        n.waitreq = 1'b1;
        if (read_i && address_i == `REG_EVT_STATUS)
          clr = s.evt_status;
        if (write_i) begin
          if (address_i <= 5'h04) begin
            n.term_sel[address_i[2:0]] = wr_word[5:0];
          end else if (address_i == `REG_RELAY_SEL) begin
            n.relay_sel = wr_word[5:0];
          end else if (address_i >= `REG_RESULT_CFG0 && address_i < `REG_TO_LIMIT) begin
            n.src1[cfg_idx[2:0]] = wr_word[`CFG_SRC1_LSB +: 6];
            n.src2[cfg_idx[2:0]] = wr_word[`CFG_SRC2_LSB +: 6];
            n.op[cfg_idx[2:0]] = wr_word[`CFG_OP_LSB +: 2];
          end else if (address_i == `REG_TO_LIMIT) begin
            n.to_limit = (wr_word[13:0] > `TO_LIMIT_MAX) ? `TO_LIMIT_MAX
                                                         : wr_word[13:0];
          end else if (address_i == `REG_FAN_CTRL) begin
            n.fan_ctrl = wr_word[1:0];
          end else if (address_i == `REG_LINK_CFG) begin
            n.link_cfg = wr_word[1:0];
          end else if (address_i == `REG_EVT_MASK) begin
            n.evt_mask = wr_word[2:0];
          end
        end
      end
    endcase
    // Reception timeout watch in 10 ms ticks
    if (!link_en) begin
      n.to_cnt = 14'h0000;
      n.link_flag = 1'b0;
    end else begin
      if (rx_data_i)
        n.to_cnt = 14'h0000;
      else if (tick && !s.link_flag && s.to_limit != 14'h0000)
        n.to_cnt = s.to_cnt + 14'h0001;
      n.link_flag = (s.link_flag & ~rx_data_i) | expire;
    end
    // Capacitor wear grows faster when hot
    if (tick && s.life_cnt < LIFE_LIMIT)
      n.life_cnt = s.life_cnt + ((temp_i > HOT_TEMP) ? 32'h0000_0002 : 32'h0000_0001);
    n.cap_warn = n.life_cnt >= LIFE_LIMIT;
    // Fan speed drop unless warnings are switched off
    n.fan_drop = fan_slow && s.fan_ctrl != `FAN_CTRL_NO_WARN;
    // Sticky events: a new event beats a clearing read
    evt = {n.fan_drop & ~s.fan_drop, n.cap_warn & ~s.cap_warn, n.link_flag & ~s.link_flag};
    n.evt_status = (s.evt_status & ~clr) | evt;
    n.irq = |(n.evt_status & n.evt_mask);
    // Registered routing to terminals and relay
    for (int i = 0; i < 5; i++)
      n.term_out[i] = route(s.term_sel[i], src_vec, results);
    n.relay_out = route(s.relay_sel, src_vec, results);
    // Synchronous reset
    if (rst_i) begin
      n = '0;
      n.bus = combiner_pkg::BUS_IDLE;
      n.waitreq = 1'b1;
      n.to_limit = `RST_TO_LIMIT;
      n.evt_mask = `RST_MASK;
    end
  end

  // State register
  always_ff @(posedge clock_i) begin
    s <= n;
  end

  // Outputs straight from the state
  assign readdata_o = s.rdata;
  assign waitrequest_o = s.waitreq;
  assign irq_o = s.irq;
  assign term_o = s.term_out;
  assign relay_o = s.relay_out;

  // Checks
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (rst_i);

  AST_OP_COMBINE: assert property (
    ##1 results[0] == (s.op[0] == `OP_AND ? (combiner_pkg::pick(src_vec, s.src1[0]) &
                                            combiner_pkg::pick(src_vec, s.src2[0])) :
                       s.op[0] == `OP_OR  ? (combiner_pkg::pick(src_vec, s.src1[0]) |
                                            combiner_pkg::pick(src_vec, s.src2[0])) :
                       s.op[0] == `OP_XOR ? (combiner_pkg::pick(src_vec, s.src1[0]) ^
                                            combiner_pkg::pick(src_vec, s.src2[0])) : 1'b0))
    else $error("result 1 does not match its operator");
  AST_NO_CHAIN: assert property (
    s.src1[1] >= `CODE_RESULT_LO && s.src1[1] <= `CODE_RESULT_HI && s.op[1] == `OP_AND
    |-> !results[1])
    else $error("a result was used as a source");
  AST_ROUTE_TERM: assert property (
    ##1 $stable(s.term_sel[0]) && s.term_sel[0] == `CODE_RESULT_LO |-> term_o[0] == $past(results[0]))
    else $error("terminal 11 does not carry result 1 one cycle later");
  AST_ROUTE_RELAY: assert property (
    ##1 $stable(s.relay_sel) && s.relay_sel == `CODE_RESULT_HI |-> relay_o == $past(results[5]))
    else $error("relay does not carry result 6 one cycle later");
  AST_LINK_OFF: assert property (
    ##1 !$past(link_en) |-> !s.link_flag)
    else $error("link flag active while link not ModBus over RS485");
  AST_LINK_HOLD: assert property (
    s.link_flag && link_en && !rx_data_i |=> s.link_flag)
    else $error("link flag dropped before data arrived");
  AST_LINK_TICK: assert property (
    $rose(s.link_flag) |-> $past(tick) && $past(s.to_limit) != 14'h0000)
    else $error("link flag rose without an expired limit");
  AST_FAN_SUPPRESS: assert property (
    s.fan_ctrl == `FAN_CTRL_NO_WARN |=> !s.fan_drop)
    else $error("fan flag set while suppressed");
  AST_FAN_LEVEL: assert property (
    fan_slow && s.fan_ctrl != `FAN_CTRL_NO_WARN |=> s.fan_drop)
    else $error("fan flag missing at low speed");
  AST_CAP_RISE: assert property (
    $rose(s.cap_warn) |-> $past(tick) && s.life_cnt >= LIFE_LIMIT)
    else $error("capacitor warning rose without wear limit");
  AST_MONITOR_READ: assert property (
    s.bus == combiner_pkg::BUS_IDLE && read_i && address_i == `REG_MONITOR
    |=> !waitrequest_o && readdata_o[`MON_CAP_BIT] == $past(s.cap_warn) &&
        readdata_o[`MON_FAN_BIT] == $past(s.fan_drop))
    else $error("monitor read does not show flags");
  AST_IRQ_LEVEL: assert property (
    irq_o == |(s.evt_status & s.evt_mask))
    else $error("interrupt level disagrees with status and mask");

  COV_RESULT_ROUTED: cover property (term_o[0] && s.term_sel[0] == `CODE_RESULT_LO);
  COV_LINK_TIMEOUT: cover property ($rose(s.link_flag));
  COV_FAN_DROP: cover property ($rose(s.fan_drop));
  COV_STATUS_READ: cover property (s.bus == combiner_pkg::BUS_ACK && read_i &&
                                   address_i == `REG_EVT_STATUS && s.evt_status != 3'h0);

endmodule

`default_nettype wire

//--- testbench/terminal_load.sv
`timescale 1ns/1ps
`default_nettype none

// Equipment wired to terminals 11 to 15 and the alarm relay; it only senses levels
module terminal_load (
  // Levels from the combiner
  input  wire logic [4:0] term_i,
  input  wire logic       relay_i,
  // Levels as the equipment senses them
  output logic [5:0]      seen_o
);
  // Relay contact in the top bit, terminals below it
  assign seen_o = {relay_i, term_i};
endmodule

`default_nettype wire

//--- testbench/tb_output_signal_logic_combiner.sv
`timescale 1ns/1ps
`default_nettype none
`include "combiner_map.svh"

module tb_output_signal_logic_combiner;
  logic        clock_i;
  logic        rst_i;
  logic [4:0]  address_i;
  logic        read_i;
  logic        write_i;
  logic [31:0] writedata_i;
  logic [3:0]  byteenable_i;
  logic [31:0] readdata_o;
  logic        waitrequest_o;
  logic        irq_o;
  logic [56:0] out_sig_i;
  logic        rx_data_i;
  logic [7:0]  temp_i;
  logic [7:0]  fan_speed_i;
  logic [4:0]  term_o;
  logic        relay_o;
  logic [5:0]  seen;
  logic        pin_chk;
  logic [31:0] exp_q[$];
  int          fail_count;
  int          num_checks;
  int          seed;
  logic [5:0]  s1[6];
  logic [5:0]  s2[6];
  logic [5:0]  res;
  logic [56:0] sig;

  // Short counts so timeouts and wear show within the run
  output_signal_logic_combiner #(
    .TICK_CYCLES (4),
    .LIFE_LIMIT  (32'h0000_0400)
  ) output_signal_logic_combiner_i (
    .clock_i       (clock_i),
    .rst_i         (rst_i),
    .address_i     (address_i),
    .read_i        (read_i),
    .write_i       (write_i),
    .writedata_i   (writedata_i),
    .byteenable_i  (byteenable_i),
    .readdata_o    (readdata_o),
    .waitrequest_o (waitrequest_o),
    .irq_o         (irq_o),
    .out_sig_i     (out_sig_i),
    .rx_data_i     (rx_data_i),
    .temp_i        (temp_i),
    .fan_speed_i   (fan_speed_i),
    .term_o        (term_o),
    .relay_o       (relay_o)
  );

  terminal_load terminal_load_i (
    .term_i  (term_o),
    .relay_i (relay_o),
    .seen_o  (seen)
  );

  // Source level as the combiner must see it: flags idle, results never chain
  function automatic logic src_lvl(logic [56:0] v, logic [5:0] c);
    return (c >= 6'h20 && c <= 6'h28) ? 1'b0 : v[c];
  endfunction

  function automatic logic op_lvl(logic [1:0] op, logic a, logic b);
    case (op)
      `OP_AND: return a & b;
      `OP_OR:  return a | b;
      `OP_XOR: return a ^ b;
      default: return 1'b0;
    endcase
  endfunction

  task automatic check(logic [31:0] seen_v, logic [31:0] exp_v);
    num_checks++;
    if (seen_v !== exp_v) begin
      $display("Error at %0t: seen %h expected %h", $time, seen_v, exp_v);
      fail_count++;
    end
  endtask

  task automatic stop_test();
    if (fail_count == 0 && num_checks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  // One Avalon access, held until waitrequest is sampled low
  task automatic bus(logic w, logic [4:0] a, logic [31:0] d, logic [3:0] be);
    int n;
    @(posedge clock_i);
    address_i    <= a;
    read_i       <= !w;
    write_i      <= w;
    writedata_i  <= d;
    byteenable_i <= be;
    n = 0;
    do begin
      @(posedge clock_i);
      n++;
    end while (waitrequest_o !== 1'b0 && n < 20);
    read_i  <= 1'b0;
    write_i <= 1'b0;
    if (waitrequest_o !== 1'b0) begin
      fail_count++;
      stop_test();
    end
  endtask

  task automatic wr(logic [4:0] a, logic [31:0] d);
    bus(1'b1, a, d, 4'hF);
  endtask

  task automatic rd(logic [4:0] a, logic [31:0] e);
    exp_q.push_back(e);
    bus(1'b0, a, 32'h0, 4'hF);
  endtask

  // Note the expected {irq, relay, terminals} and ask for a mid-cycle look
  task automatic pins(logic [31:0] e);
    exp_q.push_back(e);
    pin_chk <= 1'b1;
    @(posedge clock_i);
    pin_chk <= 1'b0;
  endtask

  // Read data compared at the edge that completes the read
  always @(posedge clock_i) begin
    if (read_i && waitrequest_o === 1'b0) begin
      check(readdata_o, exp_q.pop_front());
    end
  end

  // Pin levels compared mid-cycle when the driver asks
  always @(negedge clock_i) begin
    if (pin_chk) begin
      check({25'h0, irq_o, seen}, exp_q.pop_front());
    end
  end

  initial begin
    clock_i = 1'b0;
    forever #4 clock_i = ~clock_i;
  end

  initial begin
    seed = 32'he41891fd;
    rst_i = 1'b1;
    address_i = 5'h00;
    read_i = 1'b0;
    write_i = 1'b0;
    writedata_i = 32'h0;
    byteenable_i = 4'hF;
    out_sig_i = 57'h0;
    rx_data_i = 1'b0;
    temp_i = 8'h20;
    fan_speed_i = 8'hFF;
    pin_chk = 1'b0;
    fail_count = 0;
    num_checks = 0;
    repeat (12) @(posedge clock_i);
    rst_i <= 1'b0;
    @(posedge clock_i);
    // Reset values, with an ignored write to an unmapped place
    wr(5'h12, 32'hFFFF_FFFF);
    for (int a = 0; a <= 18; a++) begin
      rd(5'(a), 32'h0);
    end
    // Terminals carry results 1 to 5, the relay result 6
    for (int k = 0; k < 5; k++) begin
      wr(5'(k), 32'h21 + 32'(k));
    end
    wr(`REG_RELAY_SEL, 32'h26);
    bus(1'b1, 5'h00, 32'h3F, 4'h0);
    rd(5'h00, 32'h21);
    // Every operator code on all six results with random sources
    for (int op = 0; op < 4; op++) begin
      for (int r = 0; r < 6; r++) begin
        s1[r] = 6'(($random(seed) & 63) % 57);
        s2[r] = 6'(($random(seed) & 63) % 57);
        wr(`REG_RESULT_CFG0 + 5'(r), {14'h0, 2'(op), 2'h0, s2[r], 2'h0, s1[r]});
      end
      repeat (2) begin
        sig = 57'({$random(seed), $random(seed)});
        @(posedge clock_i);
        out_sig_i <= sig;
        @(posedge clock_i);
        for (int r = 0; r < 6; r++) begin
          res[r] = op_lvl(2'(op), src_lvl(sig, s1[r]), src_lvl(sig, s2[r]));
        end
        pins({26'h0, res});
        rd(`REG_MONITOR, {18'h0, res, 8'h0});
      end
    end
    out_sig_i <= 57'h0;
    // Link flag on terminal 11, fan flag on 12, capacitor warning on the relay
    wr(5'h00, 32'h20);
    wr(5'h01, 32'h28);
    wr(`REG_RELAY_SEL, 32'h27);
    wr(`REG_TO_LIMIT, 32'h3);
    wr(`REG_LINK_CFG, 32'h1);
    repeat (40) @(posedge clock_i);
    pins(32'h0);
    wr(`REG_LINK_CFG, 32'h3);
    repeat (40) @(posedge clock_i);
    pins(32'h01);
    rd(`REG_MONITOR, 32'h4);
    wr(`REG_EVT_MASK, 32'h1);
    @(posedge clock_i);
    pins(32'h41);
    rd(`REG_EVT_STATUS, 32'h1);
    @(posedge clock_i);
    pins(32'h01);
    rx_data_i <= 1'b1;
    @(posedge clock_i);
    rx_data_i <= 1'b0;
    repeat (3) @(posedge clock_i);
    pins(32'h0);
    wr(`REG_TO_LIMIT, 32'hFFFF);
    rd(`REG_TO_LIMIT, 32'h270F);
    wr(`REG_TO_LIMIT, 32'h0);
    repeat (40) @(posedge clock_i);
    pins(32'h0);
    // Fan speed either side of the threshold, then suppressed
    wr(`REG_EVT_MASK, 32'h7);
    fan_speed_i <= 8'hC0;
    repeat (4) @(posedge clock_i);
    pins(32'h0);
    fan_speed_i <= 8'hBF;
    repeat (4) @(posedge clock_i);
    pins(32'h42);
    rd(`REG_MONITOR, 32'h2);
    rd(`REG_EVT_STATUS, 32'h4);
    @(posedge clock_i);
    pins(32'h02);
    wr(`REG_FAN_CTRL, 32'h1);
    repeat (4) @(posedge clock_i);
    pins(32'h0);
    // Hot running wears the capacitors until the warning rises
    temp_i <= 8'h51;
    for (int n = 0; n < 3000 && relay_o !== 1'b1; n++) begin
      @(posedge clock_i);
    end
    // A warning that never comes ends the run as a failure
    if (relay_o !== 1'b1) begin
      fail_count++;
      stop_test();
    end
    repeat (2) @(posedge clock_i);
    pins(32'h60);
    rd(`REG_MONITOR, 32'h1);
    rd(`REG_EVT_STATUS, 32'h2);
    stop_test();
  end
endmodule

`default_nettype wire
